// >>> shared/uart_line_pkg.sv
// Purpose: Constants and types for the serial line-condition block.
// Assumes: Word-wide register port, one core clock, 16x oversampled receiver.
// Notes: Offsets are byte addresses of aligned 32-bit words.
// Operation
// - Idle limit zero disables idle detection; expired flag stays zero.
// - Nonzero limit loads 16-bit down-counter, decremented per bit, reloaded per character.
// - Idle counter reaching zero raises the idle-expired flag.
// - Arm command stops idle counting until the first character arrives.
// - Reload command restarts counting at once from the idle limit.
// - Low stop bit sets the stop-bit-error flag at mid stop bit.
// - Stop-bit-error flag holds until the clear-status command.
// - Line break holds output low at least one character, until end command.
// - Break requested mid-character waits until that character is finished.
// - Further begin-break commands are ignored until the post-break high time has ended.
// - Early end-break command never shortens break below one character.
// - Break commands need holding-free; break start clears holding-free and all-idle.
// - End-break without a preceding begin-break is ignored.
// - Holding-register write while a break is pending is discarded.
// - After break, output high for max of 12 bits and gap length.
// - All-zero character with low stop is a break, not a stop-bit error.
// - Low stop bit of a break sets the line-break flag until clear-status.
// - End of break after 2/16 bit high (async) or one sample (sync) sets flag.
// - Nonzero gap length holds output high that many bits after each character.
package uart_line_pkg;

  // Register byte offsets
  localparam logic [4:0] CMD_OFS = 5'h00;
  localparam logic [4:0] MODE_OFS = 5'h04;
  localparam logic [4:0] IDLE_LIMIT_OFS = 5'h08;
  localparam logic [4:0] GAP_OFS = 5'h0C;
  localparam logic [4:0] STATUS_OFS = 5'h10;
  localparam logic [4:0] HOLD_OFS = 5'h14;
  localparam logic [4:0] RXDATA_OFS = 5'h18;
  localparam logic [4:0] BAUD_OFS = 5'h1C;

  // command_reg bit positions
  localparam int unsigned CMD_CLEAR_STATUS = 0;
  localparam int unsigned CMD_BEGIN_BREAK = 1;
  localparam int unsigned CMD_END_BREAK = 2;
  localparam int unsigned CMD_ARM_IDLE = 3;
  localparam int unsigned CMD_RELOAD_IDLE = 4;

  // channel_status_reg bit positions
  localparam int unsigned ST_TX_HOLDING_FREE = 0;
  localparam int unsigned ST_TX_ALL_IDLE = 1;
  localparam int unsigned ST_STOP_ERR = 2;
  localparam int unsigned ST_LINE_BREAK = 3;
  localparam int unsigned ST_IDLE_EXPIRED = 4;
  localparam int unsigned ST_RX_READY = 5;

  // Mode register field
  localparam int unsigned MODE_SYNC = 0;

  // Reset values
  localparam logic [15:0] BAUD_DIV_RST = 16'h0000;
  localparam logic [15:0] IDLE_LIMIT_RST = 16'h0000;

  // Timing counts, all in bit periods or oversample ticks
  localparam logic [3:0] CHAR_BITS = 4'hA;
  localparam logic [7:0] POST_BREAK_BITS = 8'h0C;
  localparam logic [3:0] START_MID_TICK = 4'h7;
  localparam logic [1:0] EOB_ASYNC_SAMPLES = 2'h2;
  localparam logic [1:0] EOB_SYNC_SAMPLES = 2'h1;

  typedef enum logic [4:0] {
    RX_IDLE = 5'h01,
    RX_START = 5'h02,
    RX_DATA = 5'h04,
    RX_STOP = 5'h08,
    RX_BREAK = 5'h10
  } rx_state_t;

  typedef enum logic [4:0] {
    TX_IDLE = 5'h01,
    TX_SHIFT = 5'h02,
    TX_GAP = 5'h04,
    TX_BREAK = 5'h08,
    TX_POST = 5'h10
  } tx_state_t;

endpackage

// >>> design/uart_line_cond.sv
// Purpose: Receiver idle timer, stop-bit error, line break send and detect.
// Assumes: 8 data bits, no parity, one stop bit; baud ticks from a divider.
// Notes: Commands and data arrive on a plain one-cycle register port.
`timescale 1ns/1ps
`default_nettype none
module uart_line_cond #(
  parameter int unsigned GAP_W = 8 // Width of the gap length field
) (
  input wire logic I_CORE_CLK, // Core clock, 200 MHz
  input wire logic I_RST, // Asynchronous reset, active high
  input wire logic I_CE, // Clock enable, freezes all state but O_RDATA, which is cleared to zero, when low
  input wire logic [4:0] I_ADDR, // Register byte address
  input wire logic [31:0] I_WDATA, // Write data
  input wire logic I_WR, // Write strobe
  input wire logic I_RD, // Read strobe
  output logic [31:0] O_RDATA, // Read data, valid the cycle after I_RD
  input wire logic I_RXD, // Serial input pin
  output logic O_TXD // Serial output pin
);

  // Gap length field narrower than 4 or wider than 8 bits is not served
  if (GAP_W < 4 || GAP_W > 8) begin : gap_w_check
    $error("GAP_W must be 4 to 8");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register port decode
  logic sync_mode_reg;
  logic [15:0] baud_div_reg;
  logic [15:0] idle_limit_reg;
  logic [GAP_W-1:0] gap_length;
  logic wr_cmd, wr_hold, both_break;
  logic clear_status_cmd, begin_line_break_cmd, end_line_break_cmd;
  logic arm_idle_count_cmd, reload_idle_count_cmd;

  assign wr_cmd = I_CE && I_WR && (I_ADDR == uart_line_pkg::CMD_OFS);
  assign wr_hold = I_CE && I_WR && (I_ADDR == uart_line_pkg::HOLD_OFS);
  // Both break bits together is undefined; dropping both is the safe answer
  assign both_break = I_WDATA[uart_line_pkg::CMD_BEGIN_BREAK]
                      && I_WDATA[uart_line_pkg::CMD_END_BREAK];
  assign clear_status_cmd = wr_cmd && I_WDATA[uart_line_pkg::CMD_CLEAR_STATUS];
  assign begin_line_break_cmd = wr_cmd && !both_break
                                && I_WDATA[uart_line_pkg::CMD_BEGIN_BREAK];
  assign end_line_break_cmd = wr_cmd && !both_break
                              && I_WDATA[uart_line_pkg::CMD_END_BREAK];
  assign arm_idle_count_cmd = wr_cmd && I_WDATA[uart_line_pkg::CMD_ARM_IDLE];
  assign reload_idle_count_cmd = wr_cmd && I_WDATA[uart_line_pkg::CMD_RELOAD_IDLE];

  // Configuration registers
  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      sync_mode_reg <= 1'b0;
      baud_div_reg <= uart_line_pkg::BAUD_DIV_RST;
      idle_limit_reg <= uart_line_pkg::IDLE_LIMIT_RST;
      gap_length <= '0;
    end else if (I_CE && I_WR) begin
      unique case (I_ADDR)
        uart_line_pkg::MODE_OFS: sync_mode_reg <= I_WDATA[uart_line_pkg::MODE_SYNC];
        uart_line_pkg::BAUD_OFS: baud_div_reg <= I_WDATA[15:0];
        uart_line_pkg::IDLE_LIMIT_OFS: idle_limit_reg <= I_WDATA[15:0];
        uart_line_pkg::GAP_OFS: gap_length <= I_WDATA[GAP_W-1:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Baud generation: oversample tick, free bit tick
  logic [15:0] baud_cnt_reg;
  logic [3:0] bit_sub_reg;
  logic tick16, bit_tick;

  assign tick16 = I_CE && (baud_cnt_reg == baud_div_reg);
  assign bit_tick = tick16 && (bit_sub_reg == 4'hF);

  // Divider runs free so idle timing is not disturbed by the transmitter
  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      baud_cnt_reg <= 16'h0000;
      bit_sub_reg <= 4'h0;
    end else if (I_CE) begin
      baud_cnt_reg <= tick16 ? 16'h0000 : baud_cnt_reg + 16'h0001;
      if (tick16) bit_sub_reg <= bit_sub_reg + 4'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receiver
  logic rxd_meta, rxd_s;
  uart_line_pkg::rx_state_t rx_state_reg;
  logic [3:0] rx_sub_reg, rx_bits_reg;
  logic [7:0] rx_shift_reg, rx_data_reg;
  logic [1:0] rx_high_reg;
  logic rx_sample, rx_at_bit, stop_eval, char_done, frame_evt, brk_start, brk_end;
  logic [3:0] spb_m1;
  logic [1:0] eob_need;

  // Two flops on the pin before anything looks at it
  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      rxd_meta <= 1'b1;
      rxd_s <= 1'b1;
    end else if (I_CE) begin
      rxd_meta <= I_RXD;
      rxd_s <= rxd_meta;
    end
  end

  // Sync mode takes one sample per bit, async sixteen
  assign rx_sample = sync_mode_reg ? bit_tick : tick16;
  assign spb_m1 = sync_mode_reg ? 4'h0 : 4'hF;
  assign eob_need = sync_mode_reg ? uart_line_pkg::EOB_SYNC_SAMPLES
                                  : uart_line_pkg::EOB_ASYNC_SAMPLES;
  assign rx_at_bit = rx_sample && (rx_sub_reg == spb_m1);
  assign stop_eval = (rx_state_reg == uart_line_pkg::RX_STOP) && rx_at_bit;
  assign char_done = stop_eval && rxd_s;
  assign frame_evt = stop_eval && !rxd_s && (rx_shift_reg != 8'h00);
  assign brk_start = stop_eval && !rxd_s && (rx_shift_reg == 8'h00);
  assign brk_end = (rx_state_reg == uart_line_pkg::RX_BREAK) && rx_sample && rxd_s
                   && ((rx_high_reg + 2'h1) >= eob_need);

  // Character framing state machine
  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      rx_state_reg <= uart_line_pkg::RX_IDLE;
      rx_sub_reg <= 4'h0;
      rx_bits_reg <= 4'h0;
      rx_shift_reg <= 8'h00;
      rx_high_reg <= 2'h0;
    end else if (rx_sample) begin
      unique case (rx_state_reg)
        uart_line_pkg::RX_IDLE: begin
          rx_sub_reg <= 4'h0;
          rx_bits_reg <= 4'h0;
          if (!rxd_s) begin
            rx_state_reg <= sync_mode_reg ? uart_line_pkg::RX_DATA : uart_line_pkg::RX_START;
          end
        end
        uart_line_pkg::RX_START: begin
          rx_sub_reg <= rx_sub_reg + 4'h1;
          if (rx_sub_reg == uart_line_pkg::START_MID_TICK) begin
            rx_sub_reg <= 4'h0;
            rx_state_reg <= rxd_s ? uart_line_pkg::RX_IDLE : uart_line_pkg::RX_DATA;
          end
        end
        uart_line_pkg::RX_DATA: begin
          rx_sub_reg <= rx_at_bit ? 4'h0 : rx_sub_reg + 4'h1;
          if (rx_at_bit) begin
            rx_shift_reg <= {rxd_s, rx_shift_reg[7:1]};
            rx_bits_reg <= rx_bits_reg + 4'h1;
            if (rx_bits_reg == 4'h7) rx_state_reg <= uart_line_pkg::RX_STOP;
          end
        end
        uart_line_pkg::RX_STOP: begin
          rx_sub_reg <= rx_at_bit ? 4'h0 : rx_sub_reg + 4'h1;
          rx_high_reg <= 2'h0;
          if (rx_at_bit) begin
            rx_state_reg <= brk_start ? uart_line_pkg::RX_BREAK : uart_line_pkg::RX_IDLE;
          end
        end
        uart_line_pkg::RX_BREAK: begin
          // High must persist over two consecutive samples (async) or one sample (sync) to end the break
          rx_high_reg <= rxd_s ? rx_high_reg + 2'h1 : 2'h0;
          if (brk_end) rx_state_reg <= uart_line_pkg::RX_IDLE;
        end
        default: rx_state_reg <= uart_line_pkg::RX_IDLE;
      endcase
    end
  end

  // Receive flags; a set in the same cycle as the clear wins
  logic stop_err_reg, rx_line_break_flag, rx_ready_reg;
  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      stop_err_reg <= 1'b0;
      rx_line_break_flag <= 1'b0;
      rx_ready_reg <= 1'b0;
      rx_data_reg <= 8'h00;
    end else if (I_CE) begin
      if (clear_status_cmd) stop_err_reg <= 1'b0;
      if (frame_evt) stop_err_reg <= 1'b1;
      if (clear_status_cmd) rx_line_break_flag <= 1'b0;
      if (brk_start || brk_end) rx_line_break_flag <= 1'b1;
      if (I_RD && I_ADDR == uart_line_pkg::RXDATA_OFS) rx_ready_reg <= 1'b0;
      if (char_done) begin
        rx_ready_reg <= 1'b1;
        rx_data_reg <= rx_shift_reg;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receiver idle timer
  logic [15:0] idle_cnt_reg;
  logic idle_run_reg, idle_expired_reg, idle_dec, idle_expire_evt;

  assign idle_dec = idle_run_reg && bit_tick && (idle_cnt_reg != 16'h0000) && !char_done
                    && !reload_idle_count_cmd && !arm_idle_count_cmd;
  assign idle_expire_evt = idle_dec && (idle_cnt_reg == 16'h0001)
                           && (idle_limit_reg != 16'h0000);

  // A character outranks commands so that the count always restarts on data
  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      idle_cnt_reg <= 16'h0000;
      idle_run_reg <= 1'b0;
    end else if (I_CE) begin
      if (char_done) begin
        idle_cnt_reg <= idle_limit_reg;
        idle_run_reg <= 1'b1;
      end else if (reload_idle_count_cmd) begin
        idle_cnt_reg <= idle_limit_reg;
        idle_run_reg <= 1'b1;
      end else if (arm_idle_count_cmd) begin
        idle_run_reg <= 1'b0;
      end else if (idle_dec) begin
        idle_cnt_reg <= idle_cnt_reg - 16'h0001;
      end
    end
  end

  // Expired flag; disabled timer forces it low
  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      idle_expired_reg <= 1'b0;
    end else if (I_CE) begin
      if (idle_limit_reg == 16'h0000) begin
        idle_expired_reg <= 1'b0;
      end else begin
        if (arm_idle_count_cmd || reload_idle_count_cmd) idle_expired_reg <= 1'b0;
        if (idle_expire_evt) idle_expired_reg <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmitter with break generation
  uart_line_pkg::tx_state_t tx_state_reg;
  logic [3:0] tx_sub_reg;
  logic [7:0] tx_bitcnt_reg;
  logic [8:0] tx_shift_reg;
  logic [7:0] hold_data_reg, gap_ext, post_len;
  logic hold_valid_reg, brk_pending_reg, brk_stop_reg, txd_reg;
  logic tx_bit, tx_holding_free, tx_all_idle, brk_busy, begin_ok, end_ok, hold_take;

  assign gap_ext = 8'(gap_length);
  assign post_len = (gap_ext > uart_line_pkg::POST_BREAK_BITS) ? gap_ext
                    : uart_line_pkg::POST_BREAK_BITS;
  assign tx_bit = tick16 && (tx_sub_reg == 4'hF);
  // A pending break occupies the holding slot like a character
  assign tx_holding_free = !hold_valid_reg && !brk_pending_reg;
  assign tx_all_idle = (tx_state_reg == uart_line_pkg::TX_IDLE) && tx_holding_free;
  assign brk_busy = brk_pending_reg || (tx_state_reg == uart_line_pkg::TX_BREAK)
                    || (tx_state_reg == uart_line_pkg::TX_POST);
  assign begin_ok = begin_line_break_cmd && tx_holding_free && !brk_busy;
  assign end_ok = end_line_break_cmd && tx_holding_free
                  && (tx_state_reg == uart_line_pkg::TX_BREAK);
  assign hold_take = wr_hold && tx_holding_free;

  // Holding register and break request
  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      hold_valid_reg <= 1'b0;
      hold_data_reg <= 8'h00;
      brk_pending_reg <= 1'b0;
      brk_stop_reg <= 1'b0;
    end else if (I_CE) begin
      if (hold_take) begin
        hold_valid_reg <= 1'b1;
        hold_data_reg <= I_WDATA[7:0];
      end else if (tx_state_reg == uart_line_pkg::TX_IDLE && !brk_pending_reg) begin
        hold_valid_reg <= 1'b0;
      end
      if (begin_ok) brk_pending_reg <= 1'b1;
      else if (tx_state_reg == uart_line_pkg::TX_IDLE) brk_pending_reg <= 1'b0;
      if (tx_state_reg != uart_line_pkg::TX_BREAK) brk_stop_reg <= 1'b0;
      if (end_ok) brk_stop_reg <= 1'b1;
    end
  end

  // Line sequencer; idle starts at once and realigns the bit phase
  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      tx_state_reg <= uart_line_pkg::TX_IDLE;
      tx_sub_reg <= 4'h0;
      tx_bitcnt_reg <= 8'h00;
      tx_shift_reg <= 9'h1FF;
      txd_reg <= 1'b1;
    end else if (I_CE) begin
      if (tick16) tx_sub_reg <= tx_sub_reg + 4'h1;
      unique case (tx_state_reg)
        uart_line_pkg::TX_IDLE: begin
          tx_sub_reg <= 4'h0;
          tx_bitcnt_reg <= 8'h00;
          txd_reg <= 1'b1;
          if (brk_pending_reg) begin
            tx_state_reg <= uart_line_pkg::TX_BREAK;
            txd_reg <= 1'b0;
          end else if (hold_valid_reg) begin
            tx_state_reg <= uart_line_pkg::TX_SHIFT;
            tx_shift_reg <= {1'b1, hold_data_reg};
            txd_reg <= 1'b0;
          end
        end
        uart_line_pkg::TX_SHIFT: begin
          // A requested break waits here until the stop bit is out
          if (tx_bit) begin
            tx_bitcnt_reg <= tx_bitcnt_reg + 8'h01;
            txd_reg <= tx_shift_reg[0];
            tx_shift_reg <= {1'b1, tx_shift_reg[8:1]};
            if (tx_bitcnt_reg == 8'(uart_line_pkg::CHAR_BITS - 4'h1)) begin
              tx_bitcnt_reg <= 8'h00;
              txd_reg <= 1'b1;
              tx_state_reg <= (gap_ext != 8'h00) ? uart_line_pkg::TX_GAP
                                                 : uart_line_pkg::TX_IDLE;
            end
          end
        end
        uart_line_pkg::TX_GAP: begin
          if (tx_bit) begin
            tx_bitcnt_reg <= tx_bitcnt_reg + 8'h01;
            if (tx_bitcnt_reg == gap_ext - 8'h01) tx_state_reg <= uart_line_pkg::TX_IDLE;
          end
        end
        uart_line_pkg::TX_BREAK: begin
          txd_reg <= 1'b0;
          if (tx_bit) begin
            if (tx_bitcnt_reg != 8'(uart_line_pkg::CHAR_BITS - 4'h1)) begin
              tx_bitcnt_reg <= tx_bitcnt_reg + 8'h01;
            end else if (brk_stop_reg) begin
              tx_bitcnt_reg <= 8'h00;
              txd_reg <= 1'b1;
              tx_state_reg <= uart_line_pkg::TX_POST;
            end
          end
        end
        uart_line_pkg::TX_POST: begin
          txd_reg <= 1'b1;
          if (tx_bit) begin
            tx_bitcnt_reg <= tx_bitcnt_reg + 8'h01;
            if (tx_bitcnt_reg == post_len - 8'h01) tx_state_reg <= uart_line_pkg::TX_IDLE;
          end
        end
        default: tx_state_reg <= uart_line_pkg::TX_IDLE;
      endcase
    end
  end

  assign O_TXD = txd_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Read port; data stand for one cycle only, zero otherwise
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (I_ADDR)
      uart_line_pkg::MODE_OFS: rd_mux[uart_line_pkg::MODE_SYNC] = sync_mode_reg;
      uart_line_pkg::BAUD_OFS: rd_mux[15:0] = baud_div_reg;
      uart_line_pkg::IDLE_LIMIT_OFS: rd_mux[15:0] = idle_limit_reg;
      uart_line_pkg::GAP_OFS: rd_mux[7:0] = gap_ext;
      uart_line_pkg::RXDATA_OFS: rd_mux[7:0] = rx_data_reg;
      uart_line_pkg::STATUS_OFS: begin
        rd_mux[uart_line_pkg::ST_TX_HOLDING_FREE] = tx_holding_free;
        rd_mux[uart_line_pkg::ST_TX_ALL_IDLE] = tx_all_idle;
        rd_mux[uart_line_pkg::ST_STOP_ERR] = stop_err_reg;
        rd_mux[uart_line_pkg::ST_LINE_BREAK] = rx_line_break_flag;
        rd_mux[uart_line_pkg::ST_IDLE_EXPIRED] = idle_expired_reg;
        rd_mux[uart_line_pkg::ST_RX_READY] = rx_ready_reg;
      end
      default: ;
    endcase
  end

  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) O_RDATA <= 32'h0000_0000;
    else O_RDATA <= (I_CE && I_RD) ? rd_mux : 32'h0000_0000;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (I_RST);

  sequence brk_leave_s;
    (tx_state_reg == uart_line_pkg::TX_BREAK) ##1 (tx_state_reg != uart_line_pkg::TX_BREAK);
  endsequence
  sequence brk_held_s;
    (tx_state_reg == uart_line_pkg::TX_BREAK) [*2];
  endsequence

  idle_off_a: assert property (I_CE && idle_limit_reg == 16'h0000 |=> !idle_expired_reg)
    else $error("idle flag set while timer disabled");
  idle_load_a: assert property (char_done |=> idle_run_reg && idle_cnt_reg == $past(idle_limit_reg))
    else $error("idle counter not reloaded on character");
  idle_expire_a: assert property (idle_expire_evt |=> idle_expired_reg)
    else $error("idle expiry not flagged");
  idle_arm_a: assert property (arm_idle_count_cmd && !char_done |=> !idle_run_reg
                               && !idle_expired_reg)
    else $error("arm command did not stop idle timer");
  stop_err_a: assert property (frame_evt |=> stop_err_reg && !$past(brk_start))
    else $error("stop-bit error not flagged");
  stop_hold_a: assert property (stop_err_reg && !clear_status_cmd |=> stop_err_reg)
    else $error("stop-bit error dropped without clear");
  brk_rx_a: assert property (brk_start && !stop_err_reg |=> !stop_err_reg && rx_line_break_flag)
    else $error("received break misreported");
  brk_low_a: assert property (brk_held_s |-> !O_TXD)
    else $error("line not low during break");
  brk_min_a: assert property (brk_leave_s |-> $past(tx_bitcnt_reg) == 8'h09)
    else $error("break shorter than one character");
  post_high_a: assert property ((tx_state_reg == uart_line_pkg::TX_POST) [*2] |-> O_TXD)
    else $error("line not high after break");
  hold_drop_a: assert property (wr_hold && brk_pending_reg |=> !hold_valid_reg)
    else $error("byte accepted while break pending");

endmodule // uart_line_cond
`default_nettype wire

// >>> tb/remote_serial.sv
// Purpose: Remote serial transmitter that drives the block's receive pin.
// Assumes: 8N1 framing, one bit is BIT_CLKS core clocks.
// Notes: The stop level and the level left afterwards are chosen per frame.
`timescale 1ns/1ps
`default_nettype none
module remote_serial #(
  parameter int BIT_CLKS = 16 // Clocks per bit
) (
  input wire logic i_clk, // Core clock
  output logic o_txd // Line toward the block, idle high
);
  initial o_txd = 1'b1;
  // Start, data LSB first, stop; a low stop makes framing faults and breaks
  task automatic send(input logic [7:0] d, input logic stop, input logic rest);
    logic [9:0] f;
    f = {stop, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      o_txd <= f[i];
      repeat (BIT_CLKS) @(posedge i_clk);
    end
    o_txd <= rest;
  endtask
  task automatic release_line;
    o_txd <= 1'b1;
  endtask
endmodule // remote_serial
`default_nettype wire

// >>> tb/tb.sv
// Purpose: Self-checking bench for the line-condition block.
// Assumes: Baud divisor 0 after reset, so one bit is 16 core clocks.
// Notes: Reads queue their expectation; a monitor judges the answer.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic rd_q = 1'b0;
  logic [4:0] addr = 5'h00;
  logic [31:0] wdata = 32'h00000000;
  logic [31:0] rdata;
  logic rxd;
  logic txd;
  logic [7:0] b;
  int mismatches = 0;
  int samples_checked = 0;
  int low_run = 0;
  int low_max = 0;
  logic [31:0] exp_q[$];
  logic [31:0] msk_q[$];
  localparam logic [4:0] st = uart_line_pkg::STATUS_OFS;
  localparam logic [31:0] fr = 32'h1 << uart_line_pkg::ST_TX_HOLDING_FREE;
  localparam logic [31:0] ai = 32'h1 << uart_line_pkg::ST_TX_ALL_IDLE;
  localparam logic [31:0] se = 32'h1 << uart_line_pkg::ST_STOP_ERR;
  localparam logic [31:0] lb = 32'h1 << uart_line_pkg::ST_LINE_BREAK;
  localparam logic [31:0] ie = 32'h1 << uart_line_pkg::ST_IDLE_EXPIRED;
  always #2.5 clk = ~clk;
  uart_line_cond u_dut (.I_CORE_CLK(clk), .I_RST(rst), .I_CE(1'b1), .I_ADDR(addr),
    .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_RXD(rxd), .O_TXD(txd));
  remote_serial u_far (.i_clk(clk), .o_txd(rxd));
  ////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic fail(input string s);
    mismatches++;
    $display("ERROR %0t %s", $time, s);
  endtask
  // Strobe dropped for a cycle so no signal is driven twice in one step
  task automatic wr_reg(input logic [4:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  // One command bit per write, never both break bits together
  task automatic cmd(input int unsigned n);
    wr_reg(uart_line_pkg::CMD_OFS, 32'h1 << n);
  endtask
  task automatic rd_reg(input logic [4:0] a, input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  // A bounded wait that runs out ends the run
  task automatic wait_txd(input logic v, input int n);
    int i;
    i = 0;
    while (txd !== v && i < n) begin
      @(posedge clk);
      i++;
    end
    if (i == n) begin
      fail("line wait expired");
      report_and_stop();
    end
  endtask
  task automatic hold_high(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      samples_checked++;
      if (txd !== 1'b1) fail("line not high");
    end
  endtask
  // Read data stand only in the cycle after the strobe
  always @(posedge clk) begin
    if (rd_q) begin
      samples_checked++;
      if ((rdata & msk_q[0]) !== exp_q[0]) fail("read mismatch");
      void'(exp_q.pop_front());
      void'(msk_q.pop_front());
    end
    rd_q <= rd;
  end
  // Longest low run on the transmit pin, to size the break
  always @(posedge clk) begin
    low_run <= (txd === 1'b0) ? low_run + 1 : 0;
    if (low_run > low_max) low_max <= low_run;
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(62056));
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd_reg(st, fr | ai, fr | ai | se | lb | ie);
    rd_reg(5'h1E, 32'h0, 32'hFFFFFFFF);
    $display("reset test done");
    wr_reg(uart_line_pkg::IDLE_LIMIT_OFS, 32'h00000003);
    cmd(uart_line_pkg::CMD_RELOAD_IDLE);
    rd_reg(st, 32'h0, ie);
    repeat (60) @(posedge clk);
    rd_reg(st, ie, ie);
    cmd(uart_line_pkg::CMD_ARM_IDLE);
    rd_reg(st, 32'h0, ie);
    repeat (100) @(posedge clk);
    rd_reg(st, 32'h0, ie);
    u_far.send(8'h5A, 1'b1, 1'b1);
    rd_reg(st, 32'h0, ie);
    rd_reg(uart_line_pkg::RXDATA_OFS, 32'h5A, 32'hFF);
    repeat (60) @(posedge clk);
    rd_reg(st, ie, ie);
    wr_reg(uart_line_pkg::IDLE_LIMIT_OFS, 32'h00000000);
    cmd(uart_line_pkg::CMD_RELOAD_IDLE);
    repeat (80) @(posedge clk);
    rd_reg(st, 32'h0, ie);
    $display("idle timer test done");
    b = 8'($urandom_range(255, 1));
    u_far.send(b, 1'b0, 1'b1);
    repeat (4) @(posedge clk);
    rd_reg(st, se, se | lb);
    rd_reg(st, se, se);
    cmd(uart_line_pkg::CMD_CLEAR_STATUS);
    rd_reg(st, 32'h0, se);
    u_far.send(8'h00, 1'b0, 1'b0);
    rd_reg(st, lb, se | lb);
    cmd(uart_line_pkg::CMD_CLEAR_STATUS);
    rd_reg(st, 32'h0, lb);
    u_far.release_line();
    repeat (8) @(posedge clk);
    rd_reg(st, lb, lb);
    // Same break in sync mode: one high sample ends it
    wr_reg(uart_line_pkg::MODE_OFS, 32'h00000001);
    u_far.send(8'h00, 1'b0, 1'b0);
    repeat (20) @(posedge clk);
    rd_reg(st, lb, se | lb);
    cmd(uart_line_pkg::CMD_CLEAR_STATUS);
    u_far.release_line();
    repeat (40) @(posedge clk);
    rd_reg(st, lb, lb);
    wr_reg(uart_line_pkg::MODE_OFS, 32'h00000000);
    $display("receive fault test done");
    cmd(uart_line_pkg::CMD_END_BREAK);
    hold_high(40);
    b = 8'($urandom());
    wr_reg(uart_line_pkg::HOLD_OFS, {24'h0, b});
    wait_txd(1'b0, 40);
    cmd(uart_line_pkg::CMD_BEGIN_BREAK);
    rd_reg(st, 32'h0, fr | ai);
    wr_reg(uart_line_pkg::HOLD_OFS, 32'h00000000);
    repeat (17) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      samples_checked++;
      if (txd !== b[i]) fail("character cut by break");
      repeat (16) @(posedge clk);
    end
    repeat (24) @(posedge clk);
    cmd(uart_line_pkg::CMD_BEGIN_BREAK);
    cmd(uart_line_pkg::CMD_END_BREAK);
    wait_txd(1'b1, 400);
    samples_checked++;
    if (low_max < 158) fail("break too short");
    hold_high(380);
    rd_reg(st, fr | ai, fr | ai);
    $display("break send test done");
    report_and_stop();
  end
endmodule // tb
`default_nettype wire
